/* File: bench/dcc_periph_model.sv */
// dcc_periph_model: i/o device side, request lines and end-of-process pin
// assumes the bench sets its wishes just after hclk edges
`timescale 1ns/1ps
`default_nettype none
module dcc_periph_model (
    // wishes from the bench
    input wire logic [7:0] want_req,
    input wire logic eop_drive,
    // pin side
    input wire logic eop_o,
    input wire logic eop_oe,
    output logic [7:0] channel_request_line,
    output logic eop_i
);
    // requests are plain levels held until dropped
    assign channel_request_line = want_req;
    // both parties pull high only when active, so overlap is high
    assign eop_i = (eop_oe & eop_o) | eop_drive;
endmodule // dcc_periph_model
`default_nettype wire

/* File: bench/dma_channel_control_chaining_tb.sv */
// dma_channel_control_chaining_tb: register table, then hand tests
// assumes a zero-wait ahb-lite slave and the peripheral model
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_chaining_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} dcc_tb_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, eop_drive = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, step;
    logic [1:0] htrans = 2'h0;
    logic [7:0] want_req = 8'h00, ack_n = 8'hFF, xfer = 8'h00, req_line, srv, stp;
    logic hready, eop_o, eop_oe, eop_i, irq;
    int fails = 0, samples_checked = 0, cyc = 0;
    // table: write, or read with expected value
    dcc_tb_row_t rows[9] = '{
        '{1'b0, 8'h10, 32'hF},  // masks set by reset
        '{1'b1, 8'h1C, 32'h2},  // clear-mask command
        '{1'b0, 8'h10, 32'h0},  // group masks clear
        '{1'b1, 8'h0C, 32'h6},  // set mask ch2
        '{1'b0, 8'h10, 32'h4},  // single bit set
        '{1'b1, 8'h10, 32'hB},  // whole group write
        '{1'b0, 8'h10, 32'hB},  // whole group read
        '{1'b1, 8'h18, 32'h15}, // chaining ch1, eop pulse expiry
        '{1'b0, 8'h48, 32'h2}}; // expiry select visible
    dcc_channel_ctl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .channel_request_line(req_line), .channel_acknowledge_n(ack_n),
        .xfer_done(xfer), .service_request(srv), .stop_reg_enable(stp), .end_of_process_line_i(eop_i),
        .end_of_process_line_o(eop_o), .end_of_process_line_oe(eop_oe), .chain_expiry_interrupt(irq));
    dcc_periph_model i_periph (.want_req(want_req), .eop_drive(eop_drive), .eop_o(eop_o),
        .eop_oe(eop_oe), .channel_request_line(req_line), .eop_i(eop_i));
    initial begin
        forever #5 hclk = ~hclk;
    end
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one single transfer; starts just after an edge, data taken at the edge ending the data phase
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            r = hrdata;
        end while (hready !== 1'b1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask
    // one transfer of ch0 while acknowledged; leaves us mid next cycle
    task automatic xfer0();
        ack_n <= 8'hFE;
        xfer <= 8'h01;
        @(posedge hclk);
        xfer <= 8'h00;
        @(negedge hclk);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr({24'h0, rows[i].a}, rows[i].d);
            else rd({24'h0, rows[i].a}, rows[i].d);
        end
        wr(32'h0, 32'h1);
        rd(32'h40, 32'h0);
        $display("table done");
        // every size, both directions, terminal count from zero
        for (int k = 0; k < 8; k++) begin
            step = (k[1:0] == 2'h2) ? 32'h2 : (k[1:0] == 2'h3) ? 32'h4 : 32'h1;
            wr(32'h00, {28'h0, k[1:0], 2'h0});
            wr(32'h04, {24'h0, 2'h2, k[2], 5'h0});
            wr(32'h1C, 32'h2);
            wr(32'h08, 32'h4);
            rd(32'h14, 32'h10);
            wr(32'h4C, 32'h0);
            wr(32'h50, 32'h100);
            wr(32'h54, 32'h0);
            xfer0();
            chk({31'h0, eop_o & eop_oe}, 32'h1);
            ack_n <= 8'hFF;
            rd(32'h58, k[2] ? 32'h100 - step : 32'h100 + step);
            rd(32'h5C, 32'hFF_FFFF);
            rd(32'h14, 32'h1);
            rd(32'h14, 32'h0);
            rd(32'h10, 32'h1);
        end
        $display("step done");
        // hardware requests against masks and the cascade channel
        want_req <= 8'h05;
        wr(32'h1C, 32'h2);
        wr(32'h3C, 32'h2);
        repeat (4) @(posedge hclk);
        chk({24'h0, srv}, 32'h5);
        wr(32'h0C, 32'h6);
        @(negedge hclk);
        chk({24'h0, srv}, 32'h1);
        wr(32'h2C, 32'h4);
        @(negedge hclk);
        chk({24'h0, srv}, 32'h0);
        wr(32'h08, 32'h6);
        @(negedge hclk);
        chk({24'h0, srv}, 32'h4);
        rd(32'h14, 32'h50);
        want_req <= 8'h00;
        wr(32'h1C, 32'h1);
        rd(32'h10, 32'hF);
        $display("mask done");
        // chained buffer on ch0
        wr(32'h1C, 32'h2);
        wr(32'h50, 32'h200);
        wr(32'h54, 32'h0);
        wr(32'h18, 32'h4);
        rd(32'h40, 32'h1);
        wr(32'h50, 32'h300);
        wr(32'h54, 32'h5);
        rd(32'h44, 32'h0);
        wr(32'h18, 32'hC);
        xfer0();
        ack_n <= 8'hFF;
        chk({31'h0, irq}, 32'h1);
        rd(32'h44, 32'h1);
        rd(32'h58, 32'h300);
        rd(32'h5C, 32'h5);
        rd(32'h10, 32'h0);
        wr(32'h18, 32'hC);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(32'h04, 32'h0);
        rd(32'h40, 32'h0);
        $display("chain done");
        // peripheral end-of-process restarts an autoinit buffer on ch0
        wr(32'h00, 32'hC0);
        wr(32'h04, 32'h90);
        wr(32'h50, 32'h400);
        wr(32'h54, 32'h9);
        xfer0();
        chk({24'h0, stp}, 32'h1);
        chk({31'h0, eop_oe}, 32'h0);
        eop_drive <= 1'b1;
        repeat (5) @(posedge hclk);
        eop_drive <= 1'b0;
        ack_n <= 8'hFF;
        rd(32'h5C, 32'h9);
        rd(32'h58, 32'h400);
        $display("eop input done");
        // mid-run reset drops software requests and sets every mask
        wr(32'h08, 32'h4);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(32'h14, 32'h0);
        rd(32'h10, 32'hF);
        $display("reset done");
        summarize();
    end
endmodule // dma_channel_control_chaining_tb
`default_nettype wire

/* File: rtl/dcc_addr_step.sv */
// dcc_addr_step: next current address after one transfer
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
`default_nettype none
module dcc_addr_step (
    // step request and result
    dcc_step_if.unit st
);
    logic [31:0] step;

    // step width follows the device data size
    always_comb begin
        unique case (st.size)
            dcc_pkg::SZ_B8, dcc_pkg::SZ_W16S: step = dcc_pkg::STEP_ONE;
            dcc_pkg::SZ_B16: step = dcc_pkg::STEP_TWO;
            dcc_pkg::SZ_B32: step = dcc_pkg::STEP_FOUR;
        endcase
    end

    // direction from the mode setting; wraps modulo 2^32
    assign st.nxt = st.dec ? st.cur - step : st.cur + step;
endmodule // dcc_addr_step
`default_nettype wire

/* File: rtl/dcc_channel_ctl.sv */
// dcc_channel_ctl: request, mask, status and buffer chaining control
// assumes an ahb-lite master, an arbiter giving acks and xfer strobes
// Function
// - extended bit 6 picks end-of-process input or output per channel
// - pin direction follows acknowledge; overlap drives only the high level
// - end-of-process input may trigger autoinitialisation of the channel
// - extended bit 7 enables the stop registers; off by default
// - address steps 1, 1, 2 or 4 by transfer size
// - mode decides increment or decrement of the current address
// - software request acts like a hardware request, ignores masking
// - software request clears on terminal count and on device reset
// - data bits 0 and 1 select the channel on indexed writes
// - terminal count sets the mask unless autoinit or chaining
// - reset sets every mask bit; master clear sets the four of its group
// - channel 4 mask also blocks the cascaded channels
// - mask bits set singly or written and read as a group
// - status terminal count bits set on count, clear on read
// - status upper bits show channels requesting service
// - chaining state clears on reset, master clear, mode access
// - chaining enable redirects address and count loads to base
// - programming complete clears the pending chaining interrupt
// - chaining bit 4: interrupt, or end-of-process pulse while acknowledged
// - chaining status shows enable flags written through bit 2
// - chaining interrupt on terminal count only; source is readable
// - terminal count when the count wraps from zero to all ones
// - clear-mask command clears all four masks of its group
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dcc_channel_ctl (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // channel handshakes
    input wire logic [7:0] channel_request_line,
    input wire logic [7:0] channel_acknowledge_n,
    input wire logic [7:0] xfer_done,
    output logic [7:0] service_request,
    output logic [7:0] stop_reg_enable,
    // end-of-process pin
    input wire logic end_of_process_line_i,
    output logic end_of_process_line_o,
    output logic end_of_process_line_oe,
    // chaining interrupt
    output logic chain_expiry_interrupt
);
    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [6:0] ap_addr;
        logic [2:0][7:0] rq_s;
        logic [2:0] eop_s;
        logic [7:0] req_hw;
        logic eop_lvl;
        logic [7:0][1:0] size;
        logic [7:0] eop_input;
        logic [7:0] stop_en;
        logic [7:0] autoinit;
        logic [7:0] dec;
        logic [7:0][1:0] xmode;
        logic [7:0] sw_req;
        logic [7:0] mask;
        logic [7:0] tc_sts;
        logic [7:0] ch_en;
        logic [7:0] prog_done;
        logic [7:0] exp_sel;
        logic [7:0] irq_src;
        logic [2:0] chsel;
        logic [7:0][31:0] base_addr;
        logic [7:0][31:0] cur_addr;
        logic [7:0][23:0] base_cnt;
        logic [7:0][23:0] cur_cnt;
        logic eop_pulse;
    } dcc_state_t;

    dcc_state_t s_q;
    dcc_state_t s_d;
    logic [7:0][31:0] nxt_addr;
    logic wr, rd, glb, grp, eop_new, eop_rise;
    logic [4:0] off;
    logic [2:0] ch;
    logic [2:0] gb;
    logic [7:0] gsel, chclr, tc_ev, ack, eop_ext, casc, req_sts, tc_plain;

    // one address stepper per channel
    for (genvar g = 0; g < dcc_pkg::NCH; g++) begin : g_step
        dcc_step_if st ();
        assign st.size = dcc_pkg::dcc_size_t'(s_q.size[g]);
        assign st.dec = s_q.dec[g];
        assign st.cur = s_q.cur_addr[g];
        assign nxt_addr[g] = st.nxt;
        dcc_addr_step u_step (.st(st));
    end

    // next state: software accesses first, hardware events last so sets win
    always_comb begin
        s_d = s_q;
        // pin inputs: a change counts once stages two and three agree
        s_d.rq_s[0] = channel_request_line;
        s_d.rq_s[1] = s_q.rq_s[0];
        s_d.rq_s[2] = s_q.rq_s[1];
        s_d.req_hw = (s_q.rq_s[1] & s_q.rq_s[2]) | (s_q.req_hw & (s_q.rq_s[1] | s_q.rq_s[2]));
        s_d.eop_s = {s_q.eop_s[1:0], end_of_process_line_i};
        eop_new = (s_q.eop_s[1] & s_q.eop_s[2]) | (s_q.eop_lvl & (s_q.eop_s[1] | s_q.eop_s[2]));
        s_d.eop_lvl = eop_new;
        eop_rise = eop_new & ~s_q.eop_lvl;
        // address phase capture, data phase decode
        s_d.ap_valid = hsel & hready & htrans[1];
        s_d.ap_write = hwrite;
        s_d.ap_addr = haddr[dcc_pkg::ADDR_W-1:0];
        wr = s_q.ap_valid & s_q.ap_write;
        rd = s_q.ap_valid & ~s_q.ap_write;
        glb = s_q.ap_addr[dcc_pkg::ABIT_GLB];
        grp = s_q.ap_addr[dcc_pkg::ABIT_GRP];
        off = s_q.ap_addr[dcc_pkg::OFF_W-1:0];
        ch = {grp, hwdata[dcc_pkg::F_CH +: 2]};
        gsel = grp ? dcc_pkg::GRP1_BITS : dcc_pkg::GRP0_BITS;
        chclr = '0;
        ack = ~channel_acknowledge_n;
        tc_ev = '0;
        eop_ext = '0;
        s_d.eop_pulse = 1'b0;

        // group register writes
        if (wr && !glb) begin
            case (off)
                dcc_pkg::OFF_EXT: begin
                    s_d.size[ch] = hwdata[dcc_pkg::F_SIZE +: 2];
                    s_d.eop_input[ch] = hwdata[dcc_pkg::F_EOPIN];
                    s_d.stop_en[ch] = hwdata[dcc_pkg::F_STOPEN];
                    chclr[ch] = 1'b1;
                end
                dcc_pkg::OFF_MODE: begin
                    s_d.autoinit[ch] = hwdata[dcc_pkg::F_AUTO];
                    s_d.dec[ch] = hwdata[dcc_pkg::F_DEC];
                    s_d.xmode[ch] = hwdata[dcc_pkg::F_XMODE +: 2];
                    chclr[ch] = 1'b1;
                end
                dcc_pkg::OFF_REQ: s_d.sw_req[ch] = hwdata[dcc_pkg::F_SETBIT];
                dcc_pkg::OFF_SMASK: s_d.mask[ch] = hwdata[dcc_pkg::F_SETBIT];
                dcc_pkg::OFF_AMASK: begin
                    for (int i = 0; i < dcc_pkg::NCH; i++) begin
                        if (gsel[i]) begin
                            s_d.mask[i] = hwdata[i % dcc_pkg::GRP];
                        end
                    end
                end
                dcc_pkg::OFF_CHAIN: begin
                    s_d.ch_en[ch] = hwdata[dcc_pkg::F_CHEN];
                    s_d.exp_sel[ch] = hwdata[dcc_pkg::F_EXPSEL];
                    s_d.prog_done[ch] = hwdata[dcc_pkg::F_CHEN] & hwdata[dcc_pkg::F_PROG];
                    if (hwdata[dcc_pkg::F_PROG]) begin
                        s_d.irq_src[ch] = 1'b0;
                    end
                end
                dcc_pkg::OFF_CMD: begin
                    if (hwdata[dcc_pkg::F_MCLR]) begin
                        for (int i = 0; i < dcc_pkg::NCH; i++) begin
                            if (gsel[i]) begin
                                s_d.sw_req[i] = 1'b0;
                                s_d.tc_sts[i] = 1'b0;
                                s_d.mask[i] = 1'b1;
                                s_d.autoinit[i] = 1'b0;
                                s_d.dec[i] = 1'b0;
                                s_d.xmode[i] = dcc_pkg::XMODE_RST[i];
                            end
                        end
                        chclr = gsel;
                    end
                    if (hwdata[dcc_pkg::F_CLRMASK]) begin
                        s_d.mask = s_d.mask & ~gsel;
                    end
                end
                default: ;
            endcase
        end

        // reads with side effects; a read carries no channel field
        if (rd && !glb) begin
            if (off == dcc_pkg::OFF_STATUS) begin
                s_d.tc_sts = s_q.tc_sts & ~gsel;
            end
            if (off == dcc_pkg::OFF_EXT || off == dcc_pkg::OFF_MODE) begin
                chclr = gsel;
            end
        end

        // address and count loads; chaining steers them to base only
        if (wr && glb) begin
            case (off)
                dcc_pkg::OFF_CHSEL: s_d.chsel = hwdata[2:0];
                dcc_pkg::OFF_ADDR: begin
                    s_d.base_addr[s_q.chsel] = hwdata;
                    if (!s_q.ch_en[s_q.chsel]) begin
                        s_d.cur_addr[s_q.chsel] = hwdata;
                    end
                end
                dcc_pkg::OFF_COUNT: begin
                    s_d.base_cnt[s_q.chsel] = hwdata[23:0];
                    if (!s_q.ch_en[s_q.chsel]) begin
                        s_d.cur_cnt[s_q.chsel] = hwdata[23:0];
                    end
                end
                default: ;
            endcase
        end

        // chaining control back to zero
        for (int i = 0; i < dcc_pkg::NCH; i++) begin
            if (chclr[i]) begin
                s_d.ch_en[i] = 1'b0;
                s_d.prog_done[i] = 1'b0;
                s_d.exp_sel[i] = 1'b0;
            end
        end

        // transfer, terminal count and end-of-process events
        for (int i = 0; i < dcc_pkg::NCH; i++) begin
            tc_ev[i] = xfer_done[i] && (s_q.cur_cnt[i] == dcc_pkg::CNT_ZERO);
            eop_ext[i] = eop_rise & ack[i] & s_q.eop_input[i];
            if (xfer_done[i]) begin
                s_d.cur_cnt[i] = s_q.cur_cnt[i] - dcc_pkg::CNT_ONE;
                s_d.cur_addr[i] = nxt_addr[i];
            end
            if (tc_ev[i]) begin
                s_d.tc_sts[i] = 1'b1;
                s_d.sw_req[i] = 1'b0;
                if (s_q.ch_en[i]) begin
                    if (s_q.prog_done[i]) begin
                        s_d.cur_addr[i] = s_q.base_addr[i];
                        s_d.cur_cnt[i] = s_q.base_cnt[i];
                        s_d.prog_done[i] = 1'b0;
                    end
                    if (s_q.exp_sel[i]) begin
                        s_d.eop_pulse = s_d.eop_pulse | ack[i];
                    end else begin
                        s_d.irq_src[i] = 1'b1;
                    end
                end else if (s_q.autoinit[i]) begin
                    s_d.cur_addr[i] = s_q.base_addr[i];
                    s_d.cur_cnt[i] = s_q.base_cnt[i];
                end else begin
                    s_d.mask[i] = 1'b1;
                    s_d.eop_pulse = s_d.eop_pulse | (ack[i] & ~s_q.eop_input[i]);
                end
            end
            // peripheral end-of-process: restart the buffer or stop the channel
            if (eop_ext[i]) begin
                s_d.sw_req[i] = 1'b0;
                if (s_q.autoinit[i]) begin
                    s_d.cur_addr[i] = s_q.base_addr[i];
                    s_d.cur_cnt[i] = s_q.base_cnt[i];
                end else begin
                    s_d.mask[i] = 1'b1;
                end
            end
        end
    end

    // state register; straps none, so reset takes constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.mask <= dcc_pkg::MASK_RST;
            s_q.size <= dcc_pkg::SIZE_RST;
            s_q.xmode <= dcc_pkg::XMODE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // requests to the arbiter; software requests bypass every mask
    assign casc = s_q.mask[dcc_pkg::CASCADE_CH] ? dcc_pkg::CASC_BITS : '0;
    assign service_request = (s_q.req_hw & ~s_q.mask & ~casc) | s_q.sw_req;
    assign req_sts = s_q.req_hw | s_q.sw_req;
    assign stop_reg_enable = s_q.stop_en;
    assign chain_expiry_interrupt = |s_q.irq_src;

    // pin driven only under an acknowledge of an output-mode channel
    assign end_of_process_line_oe = |(ack & ~s_q.eop_input);
    assign end_of_process_line_o = s_q.eop_pulse & end_of_process_line_oe;

    // zero-wait slave: always ready, always okay
    assign hreadyout = 1'b1;
    assign hresp = dcc_pkg::HRESP_OKAY;
    assign gb = {grp, 2'b00};

    // read mux of registered state; unmapped reads return zero
    always_comb begin
        hrdata = '0;
        if (rd && !glb) begin
            case (off)
                dcc_pkg::OFF_AMASK: hrdata[3:0] = s_q.mask[gb +: 4];
                dcc_pkg::OFF_STATUS: hrdata[7:0] = {req_sts[gb +: 4], s_q.tc_sts[gb +: 4]};
                default: ;
            endcase
        end else if (rd) begin
            case (off)
                dcc_pkg::OFF_CHST: hrdata[7:0] = s_q.ch_en;
                dcc_pkg::OFF_IRQSRC: hrdata[7:0] = s_q.irq_src;
                dcc_pkg::OFF_EXPIRY: hrdata[7:0] = s_q.exp_sel;
                dcc_pkg::OFF_CHSEL: hrdata[2:0] = s_q.chsel;
                dcc_pkg::OFF_CURADDR: hrdata = s_q.cur_addr[s_q.chsel];
                dcc_pkg::OFF_CURCOUNT: hrdata[23:0] = s_q.cur_cnt[s_q.chsel];
                default: ;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign tc_plain = tc_ev & ~s_q.autoinit & ~s_q.ch_en;

    AST_TC_STATUS: assert property (|tc_ev |=> (s_q.tc_sts & $past(tc_ev)) == $past(tc_ev))
        else $error("terminal count did not set status");
    AST_SWREQ_CLR: assert property (|tc_ev |=> (s_q.sw_req & $past(tc_ev)) == 8'h00)
        else $error("software request survived terminal count");
    AST_MASK_TC: assert property (|tc_plain |=> (s_q.mask & $past(tc_plain)) == $past(tc_plain))
        else $error("terminal count did not mask channel");
    AST_WRAP: assert property (tc_plain[0] |=> s_q.cur_cnt[0] == dcc_pkg::CNT_ALL)
        else $error("count did not wrap to all ones");
    AST_STEP4: assert property (xfer_done[0] && !tc_ev[0] && !eop_ext[0] && !wr
        && s_q.size[0] == dcc_pkg::SZ_B32 && !s_q.dec[0]
        |=> s_q.cur_addr[0] == $past(s_q.cur_addr[0]) + dcc_pkg::STEP_FOUR)
        else $error("32-bit step is not four");
    AST_DEC1: assert property (xfer_done[1] && !tc_ev[1] && !eop_ext[1] && !wr
        && s_q.size[1] == dcc_pkg::SZ_B8 && s_q.dec[1]
        |=> s_q.cur_addr[1] == $past(s_q.cur_addr[1]) - dcc_pkg::STEP_ONE)
        else $error("decrement by one failed");
    AST_STATUS_CLR: assert property (rd && !glb && !grp && off == dcc_pkg::OFF_STATUS
        && tc_ev[3:0] == 4'h0 |=> s_q.tc_sts[3:0] == 4'h0)
        else $error("status read did not clear count bits");
    AST_SVC_SW: assert property ((service_request & s_q.sw_req) == s_q.sw_req)
        else $error("software request was masked");
    AST_CASC: assert property (s_q.mask[dcc_pkg::CASCADE_CH] && !s_q.sw_req[0] |-> !service_request[0])
        else $error("cascaded channel not blocked");
    AST_MCLR: assert property (wr && !glb && !grp && off == dcc_pkg::OFF_CMD && hwdata[dcc_pkg::F_MCLR]
        |=> s_q.mask[3:0] == 4'hF && s_q.ch_en[3:0] == 4'h0 && s_q.sw_req[3:0] == 4'h0)
        else $error("master clear incomplete");
    AST_IRQ: assert property (|(tc_ev & s_q.ch_en & ~s_q.exp_sel) |=> chain_expiry_interrupt)
        else $error("chaining interrupt missing");
    AST_IRQ_CLR: assert property (wr && !glb && off == dcc_pkg::OFF_CHAIN && hwdata[dcc_pkg::F_PROG]
        && tc_ev == 8'h00 |=> !s_q.irq_src[$past(ch)])
        else $error("programming complete left interrupt pending");
    AST_EOP_LOW: assert property (!end_of_process_line_oe |-> !end_of_process_line_o)
        else $error("pin value without drive");
    AST_EOP_ACK: assert property (end_of_process_line_oe |-> channel_acknowledge_n != 8'hFF)
        else $error("pin driven with no acknowledge");

    COV_TC: cover property (|tc_ev ##1 rd);
    COV_IRQ: cover property ($rose(chain_expiry_interrupt));
    COV_EOP_OUT: cover property (end_of_process_line_o);
    COV_EOP_IN: cover property (|eop_ext);
endmodule // dcc_channel_ctl
`default_nettype wire

/* File: shared/dcc_pkg.sv */
// dcc_pkg: register map, field layout, reset values and encodings
// of the dma channel control block; used by the design and the stepper interface
package dcc_pkg;
    // channel organisation
    localparam int NCH = 8;
    localparam int GRP = 4;
    localparam int CASCADE_CH = 4;
    localparam logic [7:0] CASC_BITS = 8'h0F;
    localparam logic [7:0] GRP0_BITS = 8'h0F;
    localparam logic [7:0] GRP1_BITS = 8'hF0;

    // bus decode: haddr[6] picks the global block, haddr[5] the group
    localparam int ADDR_W = 7;
    localparam int OFF_W = 5;
    localparam int ABIT_GLB = 6;
    localparam int ABIT_GRP = 5;
    localparam logic HRESP_OKAY = 1'b0;

    // per-group registers (offset within the group)
    localparam logic [4:0] OFF_EXT = 5'h00;
    localparam logic [4:0] OFF_MODE = 5'h04;
    localparam logic [4:0] OFF_REQ = 5'h08;
    localparam logic [4:0] OFF_SMASK = 5'h0C;
    localparam logic [4:0] OFF_AMASK = 5'h10;
    localparam logic [4:0] OFF_STATUS = 5'h14;
    localparam logic [4:0] OFF_CHAIN = 5'h18;
    localparam logic [4:0] OFF_CMD = 5'h1C;
    // global registers (offset within the global block)
    localparam logic [4:0] OFF_CHST = 5'h00;
    localparam logic [4:0] OFF_IRQSRC = 5'h04;
    localparam logic [4:0] OFF_EXPIRY = 5'h08;
    localparam logic [4:0] OFF_CHSEL = 5'h0C;
    localparam logic [4:0] OFF_ADDR = 5'h10;
    localparam logic [4:0] OFF_COUNT = 5'h14;
    localparam logic [4:0] OFF_CURADDR = 5'h18;
    localparam logic [4:0] OFF_CURCOUNT = 5'h1C;

    // field positions
    localparam int F_CH = 0;
    localparam int F_SETBIT = 2;
    localparam int F_SIZE = 2;
    localparam int F_EOPIN = 6;
    localparam int F_STOPEN = 7;
    localparam int F_AUTO = 4;
    localparam int F_DEC = 5;
    localparam int F_XMODE = 6;
    localparam int F_CHEN = 2;
    localparam int F_PROG = 3;
    localparam int F_EXPSEL = 4;
    localparam int F_MCLR = 0;
    localparam int F_CLRMASK = 1;

    // transfer size and transfer mode encodings
    typedef enum logic [1:0] {SZ_B8, SZ_W16S, SZ_B16, SZ_B32} dcc_size_t;
    typedef enum logic [1:0] {XM_DEMAND, XM_SINGLE, XM_BLOCK, XM_CASCADE} dcc_xmode_t;
    localparam logic [31:0] STEP_ONE = 32'h0000_0001;
    localparam logic [31:0] STEP_TWO = 32'h0000_0002;
    localparam logic [31:0] STEP_FOUR = 32'h0000_0004;
    localparam logic [23:0] CNT_ZERO = 24'h00_0000;
    localparam logic [23:0] CNT_ONE = 24'h00_0001;
    localparam logic [23:0] CNT_ALL = 24'hFF_FFFF;

    // reset values: all masked, upper group 16-bit shifted, channel 4 cascade
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0][1:0] SIZE_RST = 16'h5500;
    localparam logic [7:0][1:0] XMODE_RST = 16'h0300;
endpackage

/* File: shared/dcc_step_if.sv */
// dcc_step_if: current address, size and direction into the stepper
// assumes one instance per channel inside the control block
`timescale 1ns/1ps
`default_nettype none
interface dcc_step_if;
    dcc_pkg::dcc_size_t size;
    logic dec;
    logic [31:0] cur;
    logic [31:0] nxt;
    modport user (output size, output dec, output cur, input nxt);
    modport unit (input size, input dec, input cur, output nxt);
endinterface
`default_nettype wire
